// ==== src/ephb_arb_if.sv ====
// arbitration signals between the external port and its bus arbiter
`timescale 1ns/1ps
`default_nettype none
interface ephb_arb_if;
  logic [7:0] req;        // request of every processor slot
  logic [2:0] myId;       // this device's slot
  logic       lockOwn;    // own lock request
  logic       lockPeer;   // lock line driven by the owning peer
  logic       hostHold;   // host holds the bus
  logic       grantMe;    // this device owns the bus
  logic [2:0] ownerId;
  logic       ownerValid;

  modport arb  (input req, myId, lockOwn, lockPeer, hostHold,
                output grantMe, ownerId, ownerValid);
  modport port (output req, myId, lockOwn, lockPeer, hostHold,
                input grantMe, ownerId, ownerValid);
endinterface
`default_nettype wire

// ==== src/ephb_arbiter.sv ====
// distributed rotating-priority bus arbiter with lock and fairness
`timescale 1ns/1ps
`default_nettype none
module ephb_arbiter #(
  parameter logic [15:0] FAIR_LIMIT = ephb_pkg::FAIR_LIMIT_DEF
) (
  // clock and reset
  input wire logic  clock,
  input wire logic  reset_n,
  // arbitration group
  ephb_arb_if.arb   a
);
  logic [2:0]  owner_q;
  logic        ownerValid_q;
  logic [15:0] holdCnt_q;
  logic        lockNow;
  logic        fairOut;
  logic        othersReq;
  logic [7:0]  ownerMask;

  // nearest requester after the last owner wins; the last owner comes last
  function automatic logic [2:0] pickNext(logic [7:0] r, logic [2:0] last);
    logic [2:0] idx;
    logic [2:0] pick;
    pick = last;
    for (int i = 8; i >= 1; i--) begin
      idx = last + 3'(i);
      if (r[idx]) pick = idx;
    end
    return pick;
  endfunction

  assign ownerMask = 8'h01 << owner_q;
  assign lockNow   = ownerValid_q && ((owner_q == a.myId) ? a.lockOwn : a.lockPeer);
  assign othersReq = |(a.req & ~ownerMask);
  assign fairOut   = holdCnt_q >= FAIR_LIMIT;

  // every device runs the same arbiter on the same lines, so all agree
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      owner_q      <= 3'h0;
      ownerValid_q <= 1'b0;
    end else if (a.hostHold) begin
      ownerValid_q <= 1'b0;
    end else if (!ownerValid_q || (!lockNow && (!a.req[owner_q] || (fairOut && othersReq)))) begin
      ownerValid_q <= |a.req;
      owner_q      <= pickNext(fairOut ? (a.req & ~ownerMask) : a.req, owner_q);
    end
  end

  // tenure counter for fairness, restarts with each new owner
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      holdCnt_q <= 16'h0000;
    end else if (!ownerValid_q || a.hostHold || (!lockNow && (!a.req[owner_q] || (fairOut && othersReq)))) begin
      holdCnt_q <= 16'h0000;
    end else if (!fairOut) begin
      holdCnt_q <= holdCnt_q + 16'h0001;
    end
  end

  assign a.grantMe    = ownerValid_q && (owner_q == a.myId) && !a.hostHold;
  assign a.ownerId    = owner_q;
  assign a.ownerValid = ownerValid_q;

  property p_rotate;
    @(posedge clock) disable iff (!reset_n)
    ownerValid_q && !lockNow && !a.hostHold && !a.req[owner_q] && a.req[3'(owner_q + 3'h1)]
      |=> ownerValid_q && owner_q == 3'($past(owner_q) + 3'h1);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotation skipped next requester");

  property p_lock;
    @(posedge clock) disable iff (!reset_n)
    lockNow && !a.hostHold |=> ownerValid_q && owner_q == $past(owner_q);
  endproperty
  a_lock: assert property (p_lock) else $error("locked owner lost the bus");

  property p_fair;
    @(posedge clock) disable iff (!reset_n)
    ownerValid_q && fairOut && othersReq && !lockNow && !a.hostHold
      |=> owner_q != $past(owner_q);
  endproperty
  a_fair: assert property (p_fair) else $error("owner kept bus past fairness limit");
endmodule
`default_nettype wire

// ==== src/ephb_external_port.sv ====
// external port: host slave, burst, back-off, arbitration hook-up and eprom boot
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - slave accesses by pipelined or slow protocol
// - idle, pipe depth and wait cycles programmable
// - burst steps address while burst hold stays
// - back-off aborts, grants host, releases bus
// - host reaches internal memory and registers
// - arbitration for eight processors plus host
// - bus ownership rotates among requesters
// - bus lock keeps ownership across RMW
// - fairness limits one owner's bus tenure
// - peers reach our memory via unified map
// - eprom boot loads program after reset
// - each boot read stretched sixteen wait cycles
// - boot select pin is eprom chip select
// - boot path packs bytes into words
// - eprom read and flash write via DMA
// - eprom space is 24-bit byte addressed
// - strap low at reset selects eprom boot
// - bus logic runs on the system clock
module ephb_external_port #(
  parameter logic [15:0] BOOT_WORDS = ephb_pkg::BOOT_WORDS_DEF,
  parameter logic [15:0] FAIR_LIMIT = ephb_pkg::FAIR_LIMIT_DEF
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // static setup from same-clock logic
  input  wire logic        slowProtocol,
  input  wire logic [1:0]  idleCycles,
  input  wire logic [1:0]  pipeDepth,
  input  wire logic [3:0]  waitCycles,
  input  wire logic [2:0]  procId,
  input  wire logic        lockRequest,
  // shared bus pins
  input  wire logic [31:0] busAddrIn,
  output logic      [31:0] busAddrOut,
  output logic             busAddrOe_n,
  input  wire logic [31:0] busDataIn,
  output logic      [31:0] busDataOut,
  output logic             busDataOe_n,
  input  wire logic        hostRead,
  input  wire logic        hostWrite,
  input  wire logic        burstHold,
  input  wire logic        backOffRequest,
  input  wire logic        hostBusRequest,
  output logic             hostBusGrant,
  output logic             slaveAck,
  input  wire logic [7:0]  peerBusRequest,
  output logic             busRequestOut,
  input  wire logic        peerBusLock,
  output logic             busLockOut,
  // eprom pins
  input  wire logic        bootStrap,
  output logic             bootSelectChipSelect_n,
  output logic             epromRead_n,
  output logic             epromWrite_n,
  // internal memory and register port
  output logic             intReq,
  output logic             intWrite,
  output logic      [31:0] intAddr,
  output logic      [31:0] intWdata,
  input  wire logic [31:0] intRdata,
  input  wire logic        intAck,
  // dma channel zero eprom and flash requests
  input  wire logic        dmaReq,
  input  wire logic        dmaWrite,
  input  wire logic [23:0] dmaByteAddr,
  input  wire logic [7:0]  dmaWdata,
  output logic      [7:0]  dmaRdata,
  output logic             dmaAck,
  output logic             bootDone
);
  localparam int PIN_W = 32 + 32 + 6 + 8 + 1;

  ephb_arb_if arb ();
  ephb_pkg::ephb_slave_e  sl_q;
  ephb_pkg::ephb_master_e ms_q;

  logic [PIN_W-1:0] pinMeta_q;
  logic [PIN_W-1:0] pinSync_q;
  logic [31:0] busAddrS, busDataS;
  logic        hostReadS, hostWriteS, burstHoldS, backOffS, hostBusReqS, peerLockS, strapS;
  logic [7:0]  peerReqS;
  logic [31:0] slAddr_q, slWdata_q, slRdata_q;
  logic        slWrite_q, burstActive_q, slaveAck_q, burstHit;
  logic [3:0]  slCnt_q, slDelay;
  logic        slaveUses, portBoot_q, bootMode_q, curWrite_q, dmaAck_q, bootDone_q;
  logic [23:0] byteAddr_q;
  logic [4:0]  waitCnt_q;
  logic [31:0] pack_q, busDataOut_q;
  logic [1:0]  byteIdx_q;
  logic [15:0] wordCnt_q;
  logic [7:0]  dmaRdata_q, flashData_q, ownBit;
  logic        dataDrive_q, hostBusGrant_q, ownReq;
  logic [5:0]  xferLen_q;

  // slave claims an address in its own internal space or its own mp window
  function automatic logic isMine(logic [31:0] addr, logic [2:0] id);
    return (addr[ephb_pkg::SPACE_MSB:ephb_pkg::SPACE_LSB] == ephb_pkg::INT_SPACE_TAG) ||
           ((addr[ephb_pkg::SPACE_MSB:ephb_pkg::SPACE_LSB] == ephb_pkg::MP_SPACE_TAG) &&
            (addr[ephb_pkg::PID_MSB:ephb_pkg::PID_LSB] == id));
  endfunction

  // two flops on every pin; all bus timing is taken from this one clock
  // no reset here, so the strap level has already passed both flops when reset lifts
  always_ff @(posedge clock) begin
    pinMeta_q <= {busAddrIn, busDataIn, hostRead, hostWrite, burstHold, backOffRequest,
                  hostBusRequest, peerBusLock, peerBusRequest, bootStrap};
    pinSync_q <= pinMeta_q;
  end
  assign {busAddrS, busDataS, hostReadS, hostWriteS, burstHoldS, backOffS,
          hostBusReqS, peerLockS, peerReqS, strapS} = pinSync_q;

  // arbiter hook-up: own request replaces our own slot of the request pins
  // a transfer in flight holds the bus like a lock, so fairness never cuts it
  assign ownBit       = 8'h01 << procId;
  assign ownReq       = (ms_q == ephb_pkg::MS_REQ) || (ms_q == ephb_pkg::MS_XFER);
  assign arb.req      = (peerReqS & ~ownBit) | (ownReq ? ownBit : 8'h00);
  assign arb.myId     = procId;
  assign arb.lockOwn  = lockRequest || (ms_q == ephb_pkg::MS_XFER);
  assign arb.lockPeer = peerLockS;
  assign arb.hostHold = hostBusGrant_q;

  ephb_arbiter #(.FAIR_LIMIT(FAIR_LIMIT)) u_arb (
    .clock   (clock),
    .reset_n (reset_n),
    .a       (arb)
  );

  // ---------------- slave side ----------------
  assign slDelay   = slowProtocol ? waitCycles : {2'h0, pipeDepth};
  assign burstHit  = burstActive_q && burstHoldS;
  assign slaveUses = (sl_q == ephb_pkg::SL_ACCESS) && !portBoot_q;

  // slave sequence: take, reach inside, wait, answer, idle gap
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sl_q          <= ephb_pkg::SL_IDLE;
      slAddr_q      <= 32'h0000_0000;
      slWrite_q     <= 1'b0;
      slWdata_q     <= 32'h0000_0000;
      slRdata_q     <= 32'h0000_0000;
      slCnt_q       <= 4'h0;
      burstActive_q <= 1'b0;
    end else begin
      case (sl_q)
        ephb_pkg::SL_IDLE: begin
          if (!burstHoldS) burstActive_q <= 1'b0;
          if ((hostReadS || hostWriteS) && (burstHit || isMine(busAddrS, procId))) begin
            slAddr_q  <= burstHit ? slAddr_q + 32'h0000_0001 : busAddrS;
            slWrite_q <= hostWriteS;
            slWdata_q <= busDataS;
            sl_q      <= ephb_pkg::SL_ACCESS;
          end
        end
        ephb_pkg::SL_ACCESS: begin
          if (slaveUses && intAck) begin
            slRdata_q <= intRdata;
            slCnt_q   <= 4'h0;
            sl_q      <= ephb_pkg::SL_WAIT;
          end
        end
        ephb_pkg::SL_WAIT: begin
          if (slCnt_q == slDelay) sl_q <= ephb_pkg::SL_RESP;
          else slCnt_q <= slCnt_q + 4'h1;
        end
        ephb_pkg::SL_RESP: begin
          burstActive_q <= burstHoldS;
          slCnt_q       <= 4'h0;
          sl_q          <= (idleCycles == 2'h0) ? ephb_pkg::SL_IDLE : ephb_pkg::SL_GAP;
        end
        ephb_pkg::SL_GAP: begin
          if (slCnt_q == {2'h0, idleCycles} - 4'h1) sl_q <= ephb_pkg::SL_IDLE;
          else slCnt_q <= slCnt_q + 4'h1;
        end
        default: sl_q <= ephb_pkg::SL_IDLE;
      endcase
    end
  end

  // answer strobe marks the cycle the read data stands on the bus
  always_ff @(posedge clock) begin
    if (!reset_n) slaveAck_q <= 1'b0;
    else slaveAck_q <= (sl_q == ephb_pkg::SL_WAIT) && (slCnt_q == slDelay);
  end

  // ---------------- master side: boot and dma channel zero ----------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ms_q       <= ephb_pkg::MS_STRAP;
      bootMode_q <= 1'b0;
      curWrite_q <= 1'b0;
      byteAddr_q <= 24'h00_0000;
      waitCnt_q  <= 5'h00;
      pack_q     <= 32'h0000_0000;
      byteIdx_q  <= 2'h0;
      wordCnt_q  <= 16'h0000;
      dmaRdata_q <= 8'h00;
      bootDone_q <= 1'b0;
    end else begin
      case (ms_q)
        ephb_pkg::MS_STRAP: begin
          // strap caught by a clocked step after release, once synchronised
          if (!strapS) begin
            bootMode_q <= 1'b1;
            ms_q       <= ephb_pkg::MS_REQ;
          end else begin
            bootDone_q <= 1'b1;
            ms_q       <= ephb_pkg::MS_IDLE;
          end
        end
        ephb_pkg::MS_IDLE: begin
          if (dmaReq) begin
            byteAddr_q <= dmaByteAddr;
            curWrite_q <= dmaWrite;
            ms_q       <= ephb_pkg::MS_REQ;
          end
        end
        ephb_pkg::MS_REQ: begin
          waitCnt_q <= 5'h00;
          if (backOffS) ms_q <= ephb_pkg::MS_BACKOFF;
          else if (arb.grantMe && !hostBusGrant_q) ms_q <= ephb_pkg::MS_XFER;
        end
        ephb_pkg::MS_XFER: begin
          if (backOffS) begin
            ms_q <= ephb_pkg::MS_BACKOFF;
          end else if (waitCnt_q != ephb_pkg::EPROM_WAIT_CYCLES) begin
            waitCnt_q <= waitCnt_q + 5'h01;
          end else if (bootMode_q) begin
            pack_q     <= {busDataS[7:0], pack_q[31:8]};
            byteIdx_q  <= byteIdx_q + 2'h1;
            byteAddr_q <= byteAddr_q + 24'h00_0001;
            ms_q       <= (byteIdx_q == 2'h3) ? ephb_pkg::MS_STORE : ephb_pkg::MS_REQ;
          end else begin
            dmaRdata_q <= busDataS[7:0];
            ms_q       <= ephb_pkg::MS_ACK;
          end
        end
        ephb_pkg::MS_STORE: begin
          if (portBoot_q && intAck) begin
            wordCnt_q <= wordCnt_q + 16'h0001;
            if (wordCnt_q + 16'h0001 == BOOT_WORDS) begin
              bootMode_q <= 1'b0;
              bootDone_q <= 1'b1;
              ms_q       <= ephb_pkg::MS_IDLE;
            end else begin
              ms_q <= ephb_pkg::MS_REQ;
            end
          end
        end
        ephb_pkg::MS_BACKOFF: begin
          // address and byte index untouched, so the same access is retried
          if (!backOffS) ms_q <= ephb_pkg::MS_REQ;
        end
        ephb_pkg::MS_ACK: ms_q <= ephb_pkg::MS_IDLE;
        default: ms_q <= ephb_pkg::MS_IDLE;
      endcase
    end
  end

  // internal port owner: slave wins when both want it in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n) portBoot_q <= 1'b0;
    else if (portBoot_q && intAck) portBoot_q <= 1'b0;
    else if ((ms_q == ephb_pkg::MS_STORE) && !slaveUses) portBoot_q <= 1'b1;
  end

  // host grant: on back-off at once, on request only when no own transfer runs
  always_ff @(posedge clock) begin
    if (!reset_n) hostBusGrant_q <= 1'b0;
    else hostBusGrant_q <= backOffS ||
                           (hostBusReqS && (ms_q != ephb_pkg::MS_XFER) && !arb.grantMe);
  end

  // data lanes: slave read answer, or flash write byte for exactly the strobe cycles
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      busDataOut_q <= 32'h0000_0000;
      dataDrive_q  <= 1'b0;
    end else if ((sl_q == ephb_pkg::SL_WAIT) && (slCnt_q == slDelay) && !slWrite_q) begin
      busDataOut_q <= slRdata_q;
      dataDrive_q  <= 1'b1;
    end else if ((ms_q == ephb_pkg::MS_REQ) && curWrite_q && !bootMode_q) begin
      busDataOut_q <= {24'h00_0000, flashData_q};
      dataDrive_q  <= !backOffS && arb.grantMe && !hostBusGrant_q;
    end else begin
      dataDrive_q  <= (ms_q == ephb_pkg::MS_XFER) && curWrite_q && !bootMode_q && !backOffS &&
                      (waitCnt_q != ephb_pkg::EPROM_WAIT_CYCLES);
    end
  end

  // flash write byte and dma answer
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      flashData_q <= 8'h00;
      dmaAck_q    <= 1'b0;
    end else begin
      if ((ms_q == ephb_pkg::MS_IDLE) && dmaReq) flashData_q <= dmaWdata;
      dmaAck_q <= (ms_q == ephb_pkg::MS_XFER) && !bootMode_q && !backOffS &&
                  (waitCnt_q == ephb_pkg::EPROM_WAIT_CYCLES);
    end
  end

  // pin drive: the bus is released whenever back-off is seen
  assign busAddrOut             = {8'h00, byteAddr_q};
  assign busAddrOe_n            = !(ms_q == ephb_pkg::MS_XFER);
  assign busDataOut             = busDataOut_q;
  assign busDataOe_n            = !dataDrive_q;
  assign bootSelectChipSelect_n = !(ms_q == ephb_pkg::MS_XFER);
  assign epromRead_n            = !((ms_q == ephb_pkg::MS_XFER) && (bootMode_q || !curWrite_q));
  assign epromWrite_n           = !((ms_q == ephb_pkg::MS_XFER) && !bootMode_q && curWrite_q);
  assign hostBusGrant           = hostBusGrant_q;
  assign slaveAck               = slaveAck_q;
  assign busRequestOut          = ownReq;
  assign busLockOut             = lockRequest && arb.grantMe;
  assign intReq                 = slaveUses || portBoot_q;
  assign intWrite               = portBoot_q ? 1'b1 : slWrite_q;
  assign intAddr                = portBoot_q ? {16'h0000, wordCnt_q} : slAddr_q;
  assign intWdata               = portBoot_q ? pack_q : slWdata_q;
  assign dmaRdata               = dmaRdata_q;
  assign dmaAck                 = dmaAck_q;
  assign bootDone               = bootDone_q;

  // helper: length of each chip-select pulse
  always_ff @(posedge clock) begin
    if (!reset_n) xferLen_q <= 6'h00;
    else if (!bootSelectChipSelect_n) xferLen_q <= xferLen_q + 6'h01;
    else xferLen_q <= 6'h00;
  end

  property p_eprom_wait;
    @(posedge clock) disable iff (!reset_n)
    $rose(bootSelectChipSelect_n) && !$past(backOffS) |-> $past(xferLen_q) == 6'h10;
  endproperty
  a_eprom_wait: assert property (p_eprom_wait) else $error("eprom read not 17 cycles");

  property p_backoff;
    @(posedge clock) disable iff (!reset_n)
    backOffS |=> hostBusGrant && busAddrOe_n && bootSelectChipSelect_n;
  endproperty
  a_backoff: assert property (p_backoff) else $error("back-off did not release bus");

  property p_burst;
    @(posedge clock) disable iff (!reset_n)
    (sl_q == ephb_pkg::SL_IDLE) && (hostReadS || hostWriteS) && burstHit
      |=> slAddr_q == $past(slAddr_q) + 32'h0000_0001;
  endproperty
  a_burst: assert property (p_burst) else $error("burst address not stepped");

  sequence s_port_done;
    (sl_q == ephb_pkg::SL_ACCESS) && slaveUses && intAck && (slDelay == 4'h1);
  endsequence
  property p_slave_wait;
    @(posedge clock) disable iff (!reset_n)
    s_port_done |-> !slaveAck ##1 !slaveAck ##1 !slaveAck ##1 slaveAck;
  endproperty
  a_slave_wait: assert property (p_slave_wait) else $error("answer delay wrong");

  property p_boot_pack;
    @(posedge clock) disable iff (!reset_n)
    $rose(portBoot_q) |-> intReq && intWrite && intWdata == pack_q && bootMode_q &&
                          byteIdx_q == 2'h0;
  endproperty
  a_boot_pack: assert property (p_boot_pack) else $error("boot word store wrong");
endmodule
`default_nettype wire

// ==== src/ephb_pkg.sv ====
// shared constants and types for the external port host and multiprocessor block
package ephb_pkg;
  localparam int          NUM_PROCS         = 8;
  localparam int          ID_W              = 3;
  localparam int          ADDR_W            = 32;
  localparam int          DATA_W            = 32;
  localparam int          BYTE_ADDR_W       = 24;
  localparam int          BYTES_PER_WORD    = 4;
  // read strobe of the boot path is stretched by this many wait cycles
  localparam logic [4:0]  EPROM_WAIT_CYCLES = 5'h10;
  // unified map: space tag in the top bits, processor id below it
  localparam int          SPACE_MSB         = 31;
  localparam int          SPACE_LSB         = 26;
  localparam int          PID_MSB           = 25;
  localparam int          PID_LSB           = 23;
  localparam logic [5:0]  INT_SPACE_TAG     = 6'h00;
  localparam logic [5:0]  MP_SPACE_TAG      = 6'h01;
  // defaults for counts that a system may change
  localparam logic [15:0] FAIR_LIMIT_DEF    = 16'h0040;
  localparam logic [15:0] BOOT_WORDS_DEF    = 16'h0100;

  typedef enum logic [2:0] {
    SL_IDLE   = 3'b000,
    SL_ACCESS = 3'b001,
    SL_WAIT   = 3'b010,
    SL_RESP   = 3'b011,
    SL_GAP    = 3'b100
  } ephb_slave_e;

  typedef enum logic [2:0] {
    MS_STRAP   = 3'b000,
    MS_IDLE    = 3'b001,
    MS_REQ     = 3'b010,
    MS_XFER    = 3'b011,
    MS_STORE   = 3'b100,
    MS_BACKOFF = 3'b101,
    MS_ACK     = 3'b110
  } ephb_master_e;
endpackage

// ==== testbench/ephb_partner.sv ====
// far-side model: internal memory responder and byte-wide eprom
`timescale 1ns/1ps
`default_nettype none
module ephb_partner (
  // clock
  input  wire logic        clock,
  // internal memory port
  input  wire logic        intReq,
  input  wire logic        intWrite,
  input  wire logic [31:0] intAddr,
  input  wire logic [31:0] intWdata,
  output logic      [31:0] intRdata,
  output logic             intAck,
  // eprom pins
  input  wire logic        chipSelect_n,
  input  wire logic        read_n,
  input  wire logic [23:0] byteAddr,
  output logic      [7:0]  romData
);
  logic [31:0] mem [0:255];
  initial begin
    intAck = 1'b0;
    intRdata = 32'h0;
    romData = 8'h0;
  end
  // one ack per request; stale read data is inverted so it never passes
  always @(posedge clock) begin
    intAck <= intReq && !intAck;
    intRdata <= ~intRdata;
    if (intReq && !intAck) begin
      intRdata <= mem[intAddr[7:0]];
      if (intWrite)
        mem[intAddr[7:0]] <= intWdata;
    end
  end
  // byte pattern of the address while selected with read strobe low, toggling otherwise
  always @(posedge clock) begin
    romData <= (!chipSelect_n && !read_n) ? (byteAddr[7:0] ^ 8'hA5) : ~romData;
  end
endmodule
`default_nettype wire

// ==== testbench/tb_external_port_host_mp_boot.sv ====
// self-checking bench for the external port: boot, slave, burst, dma, back-off
`timescale 1ns/1ps
`default_nettype none
module tb_external_port_host_mp_boot;
  logic        clock, reset_n, slowProtocol, lockRequest, hostRead, hostWrite, burstHold;
  logic        backOffRequest, hostBusRequest, peerBusLock, bootStrap, dmaReq, dmaWrite;
  logic        busAddrOe_n, busDataOe_n, hostBusGrant, slaveAck, busRequestOut, busLockOut;
  logic        bootSelectChipSelect_n, epromRead_n, epromWrite_n, intReq, intWrite, intAck;
  logic        dmaAck, bootDone;
  logic [1:0]  idleCycles, pipeDepth;
  logic [3:0]  waitCycles;
  logic [2:0]  procId;
  logic [7:0]  peerBusRequest, dmaWdata, dmaRdata, romData;
  logic [23:0] dmaByteAddr;
  logic [31:0] busAddrIn, busAddrOut, busDataIn, busDataOut, hostData;
  logic [31:0] intAddr, intWdata, intRdata, rd;
  int          error_cnt, n_compared, csLen, csRun;
  assign busDataIn = bootSelectChipSelect_n ? hostData : {24'h0, romData};
  ephb_external_port #(.BOOT_WORDS(16'h0004), .FAIR_LIMIT(16'h0008)) dut (
    .clock, .reset_n, .slowProtocol, .idleCycles, .pipeDepth, .waitCycles, .procId,
    .lockRequest, .busAddrIn, .busAddrOut, .busAddrOe_n, .busDataIn, .busDataOut,
    .busDataOe_n, .hostRead, .hostWrite, .burstHold, .backOffRequest, .hostBusRequest,
    .hostBusGrant, .slaveAck, .peerBusRequest, .busRequestOut, .peerBusLock, .busLockOut,
    .bootStrap, .bootSelectChipSelect_n, .epromRead_n, .epromWrite_n, .intReq, .intWrite,
    .intAddr, .intWdata, .intRdata, .intAck, .dmaReq, .dmaWrite, .dmaByteAddr, .dmaWdata,
    .dmaRdata, .dmaAck, .bootDone);
  ephb_partner u_p (.clock, .intReq, .intWrite, .intAddr, .intWdata, .intRdata, .intAck,
    .chipSelect_n(bootSelectChipSelect_n), .read_n(epromRead_n),
    .byteAddr(busAddrOut[23:0]), .romData);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // length of the latest chip-select low run
  always @(posedge clock) begin
    if (bootSelectChipSelect_n === 1'b0) csLen++;
    else begin
      if (csLen != 0) csRun = csLen;
      csLen = 0;
    end
  end
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one host beat; address and data held until the answer or timeout
  task automatic hostAcc(input logic wr, input logic [31:0] a, input logic [31:0] d,
                         input logic expAck, output logic [31:0] r);
    int n;
    @(negedge clock);
    busAddrIn = a;
    hostData = d;
    hostWrite = wr;
    hostRead = !wr;
    @(negedge clock);
    hostWrite = 1'b0;
    hostRead = 1'b0;
    n = 0;
    while (slaveAck !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    r = busDataOut;
    chk(n < 60, expAck);
    chk(busDataOe_n, wr || !expAck);
    repeat (8) @(negedge clock);
  endtask
  task automatic t_boot();
    int n;
    n = 0;
    while (bootDone !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk(bootDone, 1'b1);
    chk(csRun, 17);
    for (int i = 0; i < 4; i++) begin
      chk(u_p.mem[i], {pat(4*i+3), pat(4*i+2), pat(4*i+1), pat(4*i)});
    end
    $display("boot test done");
  endtask
  task automatic t_slave();
    for (int p = 0; p < 2; p++) begin
      slowProtocol = p[0];
      hostAcc(1'b1, 32'h10 + p, 32'hC0DE_0000 + p, 1'b1, rd);
      hostAcc(1'b0, 32'h10 + p, 32'h0, 1'b1, rd);
      chk(rd, 32'hC0DE_0000 + p);
      hostAcc(1'b0, {6'h01, procId, 23'h10 + p[22:0]}, 32'h0, 1'b1, rd);
      chk(rd, 32'hC0DE_0000 + p);
      hostAcc(1'b0, {6'h01, procId + 3'h1, 23'h10}, 32'h0, 1'b0, rd);
    end
    $display("slave test done");
  endtask
  task automatic t_burst();
    hostAcc(1'b1, 32'h20, 32'h1111_2222, 1'b1, rd);
    hostAcc(1'b1, 32'h21, 32'h3333_4444, 1'b1, rd);
    burstHold = 1'b1;
    hostAcc(1'b0, 32'h20, 32'h0, 1'b1, rd);
    chk(rd, 32'h1111_2222);
    hostAcc(1'b0, 32'hFC00_0000, 32'h0, 1'b1, rd);
    chk(rd, 32'h3333_4444);
    burstHold = 1'b0;
    $display("burst test done");
  endtask
  // dma byte access, optionally backed off by the host mid-read
  task automatic t_dma(input logic wr, input logic [23:0] a, input logic back_off_request);
    int n;
    logic g;
    logic w;
    n = 0;
    g = 1'b0;
    w = 1'b0;
    @(negedge clock);
    dmaWrite = wr;
    dmaByteAddr = a;
    dmaWdata = 8'h5A;
    dmaReq = 1'b1;
    while (dmaAck !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
      if (back_off_request && !g && epromRead_n === 1'b0) backOffRequest = 1'b1;
      if (backOffRequest && hostBusGrant === 1'b1) begin
        chk(bootSelectChipSelect_n, 1'b1);
        backOffRequest = 1'b0;
        g = 1'b1;
      end
      if (wr && !w && epromWrite_n === 1'b0) begin
        chk(busDataOut[7:0], 8'h5A);
        chk(busAddrOut[23:0], a);
        chk(busAddrOe_n, 1'b0);
        chk(busDataOe_n, 1'b0);
        chk(busLockOut, 1'b1);
        chk(busRequestOut, 1'b1);
        w = 1'b1;
      end
    end
    dmaReq = 1'b0;
    chk(g, back_off_request);
    chk(w, wr);
    if (!wr) chk(dmaRdata, pat(a));
    repeat (4) @(negedge clock);
    $display("dma test done");
  endtask
  task automatic t_grant();
    @(negedge clock);
    hostBusRequest = 1'b1;
    repeat (10) @(negedge clock);
    chk(hostBusGrant, 1'b1);
    hostBusRequest = 1'b0;
    repeat (10) @(negedge clock);
    chk(hostBusGrant, 1'b0);
    $display("grant test done");
  endtask
  initial begin
    {reset_n, slowProtocol, lockRequest, hostRead, hostWrite, burstHold} = '0;
    {backOffRequest, hostBusRequest, peerBusLock, bootStrap, dmaReq, dmaWrite} = '0;
    {idleCycles, pipeDepth, waitCycles, procId} = {2'h2, 2'h1, 4'h3, 3'h5};
    {peerBusRequest, dmaWdata, dmaByteAddr, busAddrIn, hostData} = '0;
    {error_cnt, n_compared, csLen, csRun} = '0;
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    t_boot();
    t_slave();
    t_burst();
    t_dma(1'b0, 24'hABCDE3, 1'b0);
    lockRequest = 1'b1;
    t_dma(1'b1, 24'hFFFFFF, 1'b0);
    lockRequest = 1'b0;
    t_dma(1'b0, 24'h000107, 1'b1);
    t_grant();
    peerBusRequest = 8'h41;
    t_dma(1'b0, 24'h000033, 1'b0);
    peerBusRequest = 8'h00;
    end_sim();
  end
  initial begin
    #60000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
